// File: core/sos_defines.vh
/*
 Register map, field positions, reset values and timing constants of the
 safety output supervisor. Assumes the includer runs on one 200 MHz clock.
*/
`ifndef SOS_DEFINES_VH
`define SOS_DEFINES_VH

// Register byte addresses on the Wishbone bus
`define SOS_ADR_CTRL    8'h00
`define SOS_ADR_LATCH   8'h04
`define SOS_ADR_OFFDLY  8'h08
`define SOS_ADR_MUTELIM 8'h0C
`define SOS_ADR_FAULT   8'h10
`define SOS_ADR_STATUS  8'h14

// Reset values
`define SOS_CTRL_RST    8'h10
`define SOS_LATCH_RST   4'h0
`define SOS_OFFDLY_RST  16'h0000
`define SOS_MUTELIM_RST 16'h0000

// Control fields
`define SOS_F_MODE      1:0
`define SOS_F_OLATCH    2
`define SOS_F_MUTE      3
`define SOS_F_USED      5:4
`define SOS_F_MUTABLE   7:6

// Fault fields
`define SOS_F_INFLT     3:0
`define SOS_F_OUTFLT    5:4

// Power-up modes
`define SOS_MODE_NORMAL 2'h0
`define SOS_MODE_AUTO   2'h1
`define SOS_MODE_MANUAL 2'h2

// Clock and millisecond tick
`define SOS_CLK_MHZ     200
`define SOS_TICK_US     1000
// Cycles per ms at that clock, sized to the divider so nothing is cut
`define SOS_TICK_CYC    18'h30D40

// Times, in ms unless named otherwise
`define SOS_MS_PER_S       16'h03E8
`define SOS_STARTUP_MS     16'h03E8
`define SOS_AUTO_MAX_S     16'h0007
`define SOS_MANUAL_WAIT_S  16'h000A
`define SOS_MANUAL_WAIT_MS (`SOS_MANUAL_WAIT_S * `SOS_MS_PER_S)
`define SOS_SIMUL_MS       16'h01F4
`define SOS_EDM_MS         16'h0064

`endif

// File: core/sos_supervisor.v
/*
 Safety output supervisor: power-up modes, latch reset, off-delay,
 two-hand control with simultaneity and muting, and indicator drive.
 Assumes pins arrive asynchronously and a classic Wishbone master.
*/
// The Wishbone register port and the register addresses were chosen for this implementation.
`include "sos_defines.vh"

module sos_supervisor #(
	parameter [17:0] TICK_CYC = `SOS_TICK_CYC
) (
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [7:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	input  wire [3:0]  safety_in_i,
	input  wire [1:0]  hand_a_i,
	input  wire [1:0]  hand_b_i,
	input  wire [1:0]  mute_sensor_pair_one_i,
	input  wire        latch_reset_i,
	input  wire        powerup_reset_i,
	input  wire [1:0]  external_device_monitor_i,
	output reg         relay_output_one_o,
	output reg         relay_output_two_o,
	output reg  [3:0]  in_led_green_o,
	output reg  [3:0]  in_led_red_o,
	output reg  [1:0]  out_led_green_o,
	output reg  [1:0]  out_led_red_o
);

	localparam TH_IDLE = 2'h0;   // Both hands released
	localparam TH_ONE  = 2'h1;   // One hand down, window running
	localparam TH_GOOD = 2'h2;   // Valid two-hand start
	localparam TH_BAD  = 2'h3;   // Must release both first

	// Byte-lane merge for 16-bit registers
	function [15:0] sos_merge16;
		input [15:0] old;
		input [15:0] d;
		input [1:0]  sel;
		begin
			sos_merge16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
		end
	endfunction

	// Pin synchronisers: logic reads s2_r, and s3_r only for edge detection
	reg  [13:0] s1_r;
	reg  [13:0] s2_r;
	reg  [13:0] s3_r;   // Previous s2_r for edge detection
	wire [13:0] raw = {external_device_monitor_i, powerup_reset_i, latch_reset_i,
		mute_sensor_pair_one_i, hand_b_i, hand_a_i, safety_in_i};

	always @(posedge clk_i) begin
		if (rst_i) begin
			s1_r <= 14'h0000;
			s2_r <= 14'h0000;
			s3_r <= 14'h0000;
		end else begin
			s1_r <= raw;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	wire [3:0] run_in   = s2_r[3:0];    // High is Run
	wire [1:0] ha       = s2_r[5:4];
	wire [1:0] hb       = s2_r[7:6];
	wire       msp_act  = &s2_r[9:8];   // Whole pair active
	wire       lrst_rise = s2_r[10] & ~s3_r[10];
	wire       prst_rise = s2_r[11] & ~s3_r[11];
	wire [1:0] closed   = s2_r[13:12];  // Relay contacts closed
	wire       run_all  = &run_in;

	// Shared ms tick and blink
	wire tick;
	wire blink;

	sos_tick #(
		.TICK_CYC (TICK_CYC)
	) u_tick (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.tick_o  (tick),
		.blink_o (blink)
	);

	// Software registers
	reg  [7:0]  ctrl_r;      // Mode and two-hand setup
	reg  [3:0]  latch_r;     // Inputs with latch reset
	reg  [15:0] offdly_r;    // Off-delay in ms
	reg  [15:0] mutelim_r;   // Mute limit in ms, zero is none
	reg  [5:0]  fault_r;     // Input and relay faults
	wire [1:0]  edm_set;     // Relay mismatch events
	wire        wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire        wb_wr  = wb_req & wb_we_i;
	wire [1:0]  mode   = ctrl_r[`SOS_F_MODE];
	wire [1:0]  used   = ctrl_r[`SOS_F_USED];
	wire [1:0]  mutbl  = ctrl_r[`SOS_F_MUTABLE];

	// Register writes; relay fault bits clear on writing one
	always @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_r    <= `SOS_CTRL_RST;
			latch_r   <= `SOS_LATCH_RST;
			offdly_r  <= `SOS_OFFDLY_RST;
			mutelim_r <= `SOS_MUTELIM_RST;
			fault_r   <= 6'h00;
		end else begin
			if (wb_wr && {wb_adr_i[7:2], 2'h0} == `SOS_ADR_CTRL) begin
				if (wb_sel_i[0]) begin
					ctrl_r <= wb_dat_i[7:0];
				end
			end else if (wb_wr && {wb_adr_i[7:2], 2'h0} == `SOS_ADR_LATCH) begin
				if (wb_sel_i[0]) begin
					latch_r <= wb_dat_i[3:0];
				end
			end else if (wb_wr && {wb_adr_i[7:2], 2'h0} == `SOS_ADR_OFFDLY) begin
				offdly_r <= sos_merge16(offdly_r, wb_dat_i[15:0], wb_sel_i[1:0]);
			end else if (wb_wr && {wb_adr_i[7:2], 2'h0} == `SOS_ADR_MUTELIM) begin
				mutelim_r <= sos_merge16(mutelim_r, wb_dat_i[15:0], wb_sel_i[1:0]);
			end
			// Set beats clear so a mismatch in the clearing cycle survives
			if (wb_wr && {wb_adr_i[7:2], 2'h0} == `SOS_ADR_FAULT && wb_sel_i[0]) begin
				fault_r <= {(fault_r[5:4] & ~wb_dat_i[5:4]) | edm_set, wb_dat_i[3:0]};
			end else begin
				fault_r[5:4] <= fault_r[5:4] | edm_set;
			end
		end
	end

	// Power-up sequencing state
	reg  [15:0] pu_ms_r;     // Ms since reset, saturating
	reg         pu_done_r;   // Startup test over
	reg         man_ok_r;    // Manual power-up reset taken
	reg         latched_r;   // General output held off by a latch
	reg  [15:0] dly_r;       // Off-delay count
	wire        pu_done = pu_ms_r >= `SOS_STARTUP_MS;
	wire        pu_ok   = pu_done_r & (mode == `SOS_MODE_NORMAL ||
		mode == `SOS_MODE_AUTO || man_ok_r);
	wire        lat_use = (|latch_r) | ctrl_r[`SOS_F_OLATCH];
	wire        demand  = pu_ok & run_all & ~latched_r;
	wire        dly_act = relay_output_one_o & ~demand;

	// Power-up timer and mode gate
	always @(posedge clk_i) begin
		if (rst_i) begin
			pu_ms_r   <= 16'h0000;
			pu_done_r <= 1'b0;
			man_ok_r  <= 1'b0;
		end else begin
			if (tick && pu_ms_r < `SOS_MANUAL_WAIT_MS) begin
				pu_ms_r <= pu_ms_r + 16'h0001;
			end
			// Automatic mode enables well inside seven seconds
			pu_done_r <= pu_done;
			// Early presses are ignored: the operator must wait
			if (prst_rise && pu_ms_r >= `SOS_MANUAL_WAIT_MS) begin
				man_ok_r <= 1'b1;
			end
		end
	end

	// Latch: set by stops on latched inputs, power-up in normal mode
	always @(posedge clk_i) begin
		if (rst_i) begin
			latched_r <= 1'b0;
		end else if (pu_done && !pu_done_r && mode == `SOS_MODE_NORMAL && lat_use) begin
			latched_r <= 1'b1;
		end else if ((|(latch_r & ~run_in)) ||
			(ctrl_r[`SOS_F_OLATCH] && relay_output_one_o && !run_all)) begin
			latched_r <= 1'b1;
		end else if (lrst_rise && run_all && !dly_act && pu_ok) begin
			// A reset during the off-delay is ignored
			latched_r <= 1'b0;
		end
	end

	// General output with off-delay; restarts at Run when unlatched
	always @(posedge clk_i) begin
		if (rst_i) begin
			relay_output_one_o <= 1'b0;
			dly_r              <= 16'h0000;
		end else if (demand) begin
			relay_output_one_o <= 1'b1;
			dly_r              <= 16'h0000;
		end else if (relay_output_one_o && dly_r < offdly_r) begin
			if (tick) begin
				dly_r <= dly_r + 16'h0001;
			end
		end else begin
			relay_output_one_o <= 1'b0;
			dly_r              <= 16'h0000;
		end
	end

	// Two-hand control
	reg         mute_r;      // Mute cycle active
	reg  [15:0] mute_ms_r;   // Mute duration
	wire [1:0]  th_good;
	wire        th_kill;
	wire        all_good = (&(th_good | ~used)) & (|used);
	wire        nm_good  = &(th_good | ~used | mutbl);
	wire        mute_exp = (mutelim_r != 16'h0000) && (mute_ms_r >= mutelim_r);
	wire        th_start = pu_ok & all_good & run_all;
	wire        th_keep  = run_all & (mute_r ? (msp_act & ~mute_exp & nm_good) : all_good);

	// Any loss of the output forces every set to re-cycle its hands
	assign th_kill = (relay_output_two_o & ~th_keep) | (~relay_output_two_o & ~run_all);

	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : th_g
			reg [1:0]  st_r;    // Set state
			reg [15:0] win_r;   // Simultaneity window
			wire       a = ha[g];
			wire       b = hb[g];

			assign th_good[g] = (st_r == TH_GOOD);

			// Starts in TH_BAD so hands must go to Stop after power-up
			always @(posedge clk_i) begin
				if (rst_i) begin
					st_r  <= TH_BAD;
					win_r <= 16'h0000;
				end else if (th_kill) begin
					st_r <= TH_BAD;
				end else begin
					case (st_r)
					TH_IDLE: begin
						win_r <= 16'h0000;
						if (a && b) begin
							st_r <= TH_GOOD;
						end else if (a || b) begin
							st_r <= TH_ONE;
						end
					end
					TH_ONE: begin
						if (!a && !b) begin
							st_r <= TH_IDLE;
						end else if (a && b) begin
							st_r <= TH_GOOD;
						end else if (win_r >= `SOS_SIMUL_MS) begin
							st_r <= TH_BAD;
						end else if (tick) begin
							win_r <= win_r + 16'h0001;
						end
					end
					TH_GOOD: begin
						if (!a || !b) begin
							st_r <= TH_BAD;
						end
					end
					default: begin
						if (!a && !b) begin
							st_r <= TH_IDLE;
						end
					end
					endcase
				end
			end
		end
	endgenerate

	// Two-hand output and its mute cycle
	always @(posedge clk_i) begin
		if (rst_i) begin
			relay_output_two_o <= 1'b0;
			mute_r             <= 1'b0;
			mute_ms_r          <= 16'h0000;
		end else if (!relay_output_two_o) begin
			relay_output_two_o <= th_start;
			mute_r             <= 1'b0;
			mute_ms_r          <= 16'h0000;
		end else if (!th_keep) begin
			relay_output_two_o <= 1'b0;
			mute_r             <= 1'b0;
		end else begin
			// Mute only starts from a held valid start
			if (ctrl_r[`SOS_F_MUTE] && msp_act && all_good) begin
				mute_r <= 1'b1;
			end
			if (mute_r && tick && !mute_exp) begin
				mute_ms_r <= mute_ms_r + 16'h0001;
			end
		end
	end

	// Relay feedback check against the commanded state
	wire [1:0] cmd = {relay_output_two_o, relay_output_one_o};

	generate
		for (g = 0; g < 2; g = g + 1) begin : edm_g
			reg [15:0] mis_r;   // Mismatch duration

			// Contacts get time to settle before a mismatch is a fault
			always @(posedge clk_i) begin
				if (rst_i || cmd[g] == closed[g]) begin
					mis_r <= 16'h0000;
				end else if (tick && mis_r < `SOS_EDM_MS) begin
					mis_r <= mis_r + 16'h0001;
				end
			end

			assign edm_set[g] = (mis_r >= `SOS_EDM_MS);
		end
	endgenerate

	// Indicators: fault blinks red, otherwise green or red by level
	always @(posedge clk_i) begin
		if (rst_i) begin
			in_led_green_o  <= 4'h0;
			in_led_red_o    <= 4'h0;
			out_led_green_o <= 2'h0;
			out_led_red_o   <= 2'h0;
		end else begin
			in_led_green_o  <= run_in & ~fault_r[`SOS_F_INFLT];
			in_led_red_o    <= (fault_r[`SOS_F_INFLT] & {4{blink}}) |
				(~run_in & ~fault_r[`SOS_F_INFLT]);
			out_led_green_o <= closed & ~fault_r[`SOS_F_OUTFLT];
			out_led_red_o   <= (fault_r[`SOS_F_OUTFLT] & {2{blink}}) |
				(~closed & ~fault_r[`SOS_F_OUTFLT]);
		end
	end

	// Wishbone slave: one-cycle ack, unmapped reads return zero
	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= wb_req;
			if (wb_req && {wb_adr_i[7:2], 2'h0} == `SOS_ADR_CTRL) begin
				wb_dat_o <= {24'h000000, ctrl_r};
			end else if (wb_req && {wb_adr_i[7:2], 2'h0} == `SOS_ADR_LATCH) begin
				wb_dat_o <= {28'h0000000, latch_r};
			end else if (wb_req && {wb_adr_i[7:2], 2'h0} == `SOS_ADR_OFFDLY) begin
				wb_dat_o <= {16'h0000, offdly_r};
			end else if (wb_req && {wb_adr_i[7:2], 2'h0} == `SOS_ADR_MUTELIM) begin
				wb_dat_o <= {16'h0000, mutelim_r};
			end else if (wb_req && {wb_adr_i[7:2], 2'h0} == `SOS_ADR_FAULT) begin
				wb_dat_o <= {26'h0000000, fault_r};
			end else if (wb_req && {wb_adr_i[7:2], 2'h0} == `SOS_ADR_STATUS) begin
				wb_dat_o <= {22'h000000, closed, th_good, pu_ok, pu_done_r,
					mute_r, latched_r, relay_output_two_o, relay_output_one_o};
			end else if (wb_req) begin
				wb_dat_o <= 32'h00000000;
			end
		end
	end

endmodule

// File: core/sos_tick.v
/*
 Millisecond tick and indicator blink source for the supervisor.
 Assumes clk_i at 200 MHz and a synchronous active-high reset.
*/
`include "sos_defines.vh"

module sos_tick #(
	parameter [17:0] TICK_CYC = `SOS_TICK_CYC
) (
	input  wire clk_i,
	input  wire rst_i,
	output reg  tick_o,
	output wire blink_o
);

	reg [17:0] div_r;   // Cycle divider
	reg [7:0]  ms_r;    // Free-running ms count

	// Divider: one pulse per ms, shared by every timer of the block
	always @(posedge clk_i) begin
		if (rst_i) begin
			div_r  <= 18'h00000;
			tick_o <= 1'b0;
			ms_r   <= 8'h00;
		end else if (div_r == TICK_CYC - 18'h00001) begin
			div_r  <= 18'h00000;
			tick_o <= 1'b1;
			ms_r   <= ms_r + 8'h01;
		end else begin
			div_r  <= div_r + 18'h00001;
			tick_o <= 1'b0;
		end
	end

	// Blink period of 256 ms, slow enough to read on an indicator
	assign blink_o = ms_r[7];

endmodule

// File: sim/sos_field.sv
/*
 Field model: safety devices, hand actuators, mute sensors and loads.
 Assumes the bench asks for device states; contacts follow the relays.
*/
module sos_field (
	input  wire logic       clk_i,
	input  wire logic [3:0] run_i,
	input  wire logic [3:0] hands_i,
	input  wire logic [1:0] mute_i,
	input  wire logic       relay_one_i,
	input  wire logic       relay_two_i,
	output logic      [3:0] run_o,
	output logic      [1:0] hand_a_o,
	output logic      [1:0] hand_b_o,
	output logic      [1:0] mute_o,
	output logic      [1:0] contact_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [1:0] coil_r;  // Armature lags the coil, so contacts trail by two edges
	// Devices follow requests one edge late; loads close after the coil
	// Set g holds request bits 2g (first hand) and 2g+1 (second hand)
	always @(posedge clk_i) begin
		run_o <= run_i;
		hand_a_o <= {hands_i[2], hands_i[0]};
		hand_b_o <= {hands_i[3], hands_i[1]};
		mute_o <= mute_i;
		coil_r <= {relay_two_i, relay_one_i};
		contact_o <= coil_r;
	end
endmodule

// File: sim/sos_supervisor_asserts.sv
/*
 Port assertions for the safety output supervisor.
 Assumes one clock with a synchronous active-high reset.
*/
module sos_supervisor_asserts (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic [3:0]  safety_in_i,
	input wire logic [1:0]  hand_a_i,
	input wire logic [1:0]  hand_b_i,
	input wire logic [1:0]  external_device_monitor_i,
	input wire logic        relay_output_one_o,
	input wire logic        relay_output_two_o,
	input wire logic [3:0]  in_led_green_o,
	input wire logic [3:0]  in_led_red_o,
	input wire logic [1:0]  out_led_green_o
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// A taken request is answered next edge by a single ack pulse
	a_ack_next_pulse: assert property (
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not a one-cycle pulse after request");
	// Unmapped reads return zero
	a_unmapped_zero: assert property (
		wb_ack_o && $past(wb_cyc_i && wb_stb_i && !wb_we_i && wb_adr_i > 8'h17)
		|-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
	// Green never lit for a settled low input, never with red
	a_in_led_level: assert property (
		$stable(safety_in_i)[*4] |->
		((in_led_green_o & ~safety_in_i) | (in_led_green_o & in_led_red_o)) == 4'h0)
		else $error("input indicator wrong");
	// Relay green only while its contacts are closed
	a_relay_led: assert property (
		$stable(external_device_monitor_i)[*4] |->
		(out_led_green_o & ~external_device_monitor_i) == 2'h0)
		else $error("relay indicator wrong");
	// Two-hand output comes on only with both hands of a set held
	// Pin to output is sync, set state, output: four edges
	a_two_hand_held: assert property (
		$rose(relay_output_two_o) |-> $past(hand_a_i & hand_b_i, 4) != 2'h0)
		else $error("two-hand output on without both hands");
	// A stopped safety input keeps the two-hand output off
	a_two_hand_stop: assert property (
		(safety_in_i != 4'hF)[*4] |-> !relay_output_two_o)
		else $error("two-hand output on with input stopped");
	// General output rises only with every input in Run
	a_one_needs_run: assert property (
		$rose(relay_output_one_o) |-> $past(safety_in_i, 3) == 4'hF)
		else $error("general output on with input stopped");
	// Both outputs start off after reset
	a_reset_off: assert property (
		$fell(rst_i) |-> !relay_output_one_o && !relay_output_two_o)
		else $error("output on after reset");
endmodule

bind sos_supervisor sos_supervisor_asserts u_chk (
	.clk_i                     (clk_i),
	.rst_i                     (rst_i),
	.wb_cyc_i                  (wb_cyc_i),
	.wb_stb_i                  (wb_stb_i),
	.wb_we_i                   (wb_we_i),
	.wb_adr_i                  (wb_adr_i),
	.wb_dat_o                  (wb_dat_o),
	.wb_ack_o                  (wb_ack_o),
	.safety_in_i               (safety_in_i),
	.hand_a_i                  (hand_a_i),
	.hand_b_i                  (hand_b_i),
	.external_device_monitor_i (external_device_monitor_i),
	.relay_output_one_o        (relay_output_one_o),
	.relay_output_two_o        (relay_output_two_o),
	.in_led_green_o            (in_led_green_o),
	.in_led_red_o              (in_led_red_o),
	.out_led_green_o           (out_led_green_o)
);

// File: sim/test_safety_output_supervisor.sv
/*
 Self-checking bench for the safety output supervisor.
 Assumes the field model and a four-cycle millisecond tick.
*/
`include "sos_defines.vh"
module test_safety_output_supervisor;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int TK = 4;  // Cycles per ms; keeps the ten-second wait short
	logic        clk_i = 1'b0, rst_i = 1'b1, wb_ack_o, relay_output_one_o;
	logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, relay_output_two_o;
	logic        latch_reset_i = 1'b0, powerup_reset_i = 1'b0;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [3:0]  wb_sel_i = 4'h0, safety_in_i, in_led_green_o, in_led_red_o;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
	logic [1:0]  hand_a_i, hand_b_i, mute_sensor_pair_one_i, external_device_monitor_i;
	logic [1:0]  out_led_green_o, out_led_red_o;
	logic [3:0]  run_c = 4'hF, hand_c = 4'h0;  // Device states asked of the field
	logic [1:0]  mute_c = 2'h0;
	int          errors = 0, n_tests = 0, k, dly, i;
	int          gap [3];
	logic [31:0] mode [3];
	integer      seed = 5;
	logic        red_was;  // Faulted input's red before half a blink period
	always #2.5 clk_i = ~clk_i;
	sos_supervisor #(.TICK_CYC(18'h4)) dut (.*);
	sos_field fld (.clk_i(clk_i), .run_i(run_c), .hands_i(hand_c), .mute_i(mute_c),
		.relay_one_i(relay_output_one_o), .relay_two_i(relay_output_two_o),
		.run_o(safety_in_i), .hand_a_o(hand_a_i), .hand_b_o(hand_b_i),
		.mute_o(mute_sensor_pair_one_i), .contact_o(external_device_monitor_i));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic ms(input int n);
		repeat (n * TK) @(posedge clk_i);
	endtask
	// Classic single cycle, held until ack is seen high
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hF;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (n == 20) chk(1'b0, 1'b1);
	endtask
	task automatic pulse(input bit lr);
		if (lr) latch_reset_i <= 1'b1;
		else powerup_reset_i <= 1'b1;
		ms(1);
		latch_reset_i <= 1'b0;
		powerup_reset_i <= 1'b0;
		ms(1);
	endtask
	// Release all hands, then press first hands of mask m, the rest g ms later
	task automatic two_hand(input int g, input logic [3:0] m);
		hand_c <= 4'h0;
		ms(2);
		hand_c <= m & 4'h5;
		ms(g);
		hand_c <= m;
		ms(2);
	endtask
	task automatic stop_test;
		if (errors == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		dly = 2 + $unsigned($random(seed)) % 8;
		k = $unsigned($random(seed)) % 4;
		wb(1'b1, `SOS_ADR_OFFDLY, dly);
		wb(1'b0, 8'h18, 32'h0);
		chk(q, 32'h0);
		wb(1'b0, `SOS_ADR_CTRL, 32'h0);
		chk(q, `SOS_CTRL_RST);
		ms(900);
		chk(relay_output_one_o, 1'b0);
		ms(200);
		chk(relay_output_one_o, 1'b1);
		chk(relay_output_two_o, 1'b0);
		chk(out_led_green_o, 2'h1);
		run_c[k] <= 1'b0;
		ms(dly - 1);
		chk(relay_output_one_o, 1'b1);
		ms(4);
		chk(relay_output_one_o, 1'b0);
		chk(in_led_red_o, 32'h1 << k);
		chk(out_led_red_o, 2'h3);
		run_c[k] <= 1'b1;
		ms(2);
		chk(relay_output_one_o, 1'b1);
		wb(1'b1, `SOS_ADR_LATCH, 32'h1 << k);
		run_c[k] <= 1'b0;
		ms(dly + 2);
		run_c[k] <= 1'b1;
		ms(2);
		chk(relay_output_one_o, 1'b0);
		pulse(1'b1);
		chk(relay_output_one_o, 1'b1);
		wb(1'b1, `SOS_ADR_LATCH, 32'h0);
		// Fault on input k: green dark, red flips every 128 ms
		wb(1'b1, `SOS_ADR_FAULT, 32'h1 << k);
		wb(1'b0, `SOS_ADR_FAULT, 32'h0);
		chk(q, 32'h1 << k);
		ms(1);
		chk(in_led_green_o[k], 1'b0);
		red_was = in_led_red_o[k];
		ms(128);
		chk(in_led_red_o[k], !red_was);
		wb(1'b1, `SOS_ADR_FAULT, 32'h0);
		// Simultaneity: short, random and too-late second hand
		gap = '{1, 1 + $unsigned($random(seed)) % 450, 550};
		for (i = 0; i < 3; i++) begin
			two_hand(gap[i], 4'h3);
			chk(relay_output_two_o, i < 2);
		end
		two_hand(1, 4'h3);
		hand_c[1] <= 1'b0;
		ms(1);
		hand_c[1] <= 1'b1;
		ms(2);
		chk(relay_output_two_o, 1'b0);
		two_hand(1, 4'h3);
		run_c[k] <= 1'b0;
		ms(2);
		chk(relay_output_two_o, 1'b0);
		run_c[k] <= 1'b1;
		wb(1'b1, `SOS_ADR_CTRL, 32'h30);
		two_hand(1, 4'h3);
		chk(relay_output_two_o, 1'b0);
		two_hand(1, 4'hF);
		chk(relay_output_two_o, 1'b1);
		// Mute ends first by the pair dropping, then by the 20 ms limit
		wb(1'b1, `SOS_ADR_MUTELIM, 32'h14);
		wb(1'b1, `SOS_ADR_CTRL, 32'h58);
		for (i = 0; i < 2; i++) begin
			two_hand(1, 4'h3);
			mute_c <= 2'h3;
			ms(2);
			hand_c <= 4'h0;
			ms(10);
			chk(relay_output_two_o, 1'b1);
			if (i == 0) mute_c <= 2'h0;
			ms(12);
			chk(relay_output_two_o, 1'b0);
			mute_c <= 2'h0;
		end
		// Set 0 mutable, set 1 not: a set 1 hand ends the mute cycle
		wb(1'b1, `SOS_ADR_CTRL, 32'h78);
		two_hand(1, 4'hF);
		mute_c <= 2'h3;
		ms(2);
		hand_c <= 4'hC;
		ms(2);
		chk(relay_output_two_o, 1'b1);
		hand_c <= 4'h4;
		ms(2);
		chk(relay_output_two_o, 1'b0);
		hand_c <= 4'h0;
		mute_c <= 2'h0;
		// Power-up: normal with latching, manual, automatic
		mode = '{32'h14, 32'h12, 32'h11};
		for (i = 0; i < 3; i++) begin
			rst_i <= 1'b1;
			repeat (3) @(posedge clk_i);
			rst_i <= 1'b0;
			wb(1'b1, `SOS_ADR_CTRL, mode[i]);
			ms(1100);
			chk(relay_output_one_o, i == 2);
			if (i == 1) begin
				pulse(1'b0);
				chk(relay_output_one_o, 1'b0);
				ms(9000);
				pulse(1'b0);
				chk(relay_output_one_o, 1'b1);
			end
		end
		stop_test;
	end
	// Hang guard well beyond the expected run of some 60k cycles
	initial begin
		repeat (90000) @(posedge clk_i);
		errors++;
		stop_test;
	end
endmodule
